// *** include/nvsp_pkg.sv ***
// Shared constants and types of the nonvolatile self-program controller
package nvsp_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_UNLOCK     = 8'hF1;
  localparam logic [7:0] IDX_ADDR_LOW   = 8'hF2;
  localparam logic [7:0] IDX_ADDR_HIGH  = 8'hF3;
  localparam logic [7:0] IDX_SPACE      = 8'hF4;
  localparam logic [7:0] IDX_WRITE_BYTE = 8'hF5;
  localparam logic [7:0] IDX_CONTROL    = 8'hF6;
  localparam logic [7:0] IDX_STATUS     = 8'hF7;

  // Reset values
  localparam logic [7:0] RST_BYTE       = 8'h00;
  localparam logic [4:0] RST_ADDR_HIGH  = 5'h00;

  // Space select codes
  localparam logic [7:0] SPACE_CODE     = 8'h00;
  localparam logic [7:0] SPACE_USER_ID  = 8'h01;
  localparam logic [7:0] SPACE_EEPROM   = 8'h02;

  // Command and stall-length codes
  localparam logic [1:0] CMD_WRITE      = 2'h2;
  localparam logic [1:0] STALL_4MS      = 2'h0;
  localparam logic [1:0] STALL_2MS      = 2'h1;
  localparam logic [1:0] STALL_1MS      = 2'h2;
  localparam logic [1:0] STALL_RESERVED = 2'h3;

  // Hold lengths in milliseconds
  localparam logic [2:0] HOLD_UNITS_4MS = 3'h4;
  localparam logic [2:0] HOLD_UNITS_2MS = 3'h2;
  localparam logic [2:0] HOLD_UNITS_1MS = 3'h1;

  // Code-space write range option
  localparam logic [1:0]  RANGE_NONE    = 2'h0;
  localparam logic [1:0]  RANGE_HALF_K  = 2'h1;
  localparam logic [1:0]  RANGE_ONE_K   = 2'h2;
  localparam logic [1:0]  RANGE_ALL     = 2'h3;
  localparam logic [12:0] HALF_K_BASE   = 13'h1E00;
  localparam logic [12:0] ONE_K_BASE    = 13'h1C00;

  // Timing: one hold unit is one millisecond
  localparam int unsigned CLK_PERIOD_NS    = 50;
  localparam int unsigned HOLD_UNIT_NS     = 1000000;
  localparam int unsigned HOLD_UNIT_CYCLES = HOLD_UNIT_NS / CLK_PERIOD_NS;

  // AHB-Lite codes
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic        HRESP_OKAY    = 1'b0;
  localparam logic [31:0] RDATA_ZERO    = 32'h00000000;

  // Control register layout
  typedef struct packed {
    logic [3:0] rsvd;
    logic [1:0] stall;
    logic [1:0] cmd;
  } nvsp_ctl_t;

  // Status register layout
  typedef struct packed {
    logic [4:0] rsvd;
    logic       refused;
    logic       hold;
    logic       open;
  } nvsp_status_t;

  // Write request to the arrays
  typedef struct packed {
    logic [7:0]  space;
    logic [12:0] addr;
    logic [7:0]  data;
  } nvsp_wr_req_t;

endpackage

// *** logic/nvsp_hold_timer.sv ***
// Millisecond hold timer that freezes the program counter
`timescale 1ns/1ps
module nvsp_hold_timer #(
  parameter int unsigned UNIT_CYCLES = nvsp_pkg::HOLD_UNIT_CYCLES,
  parameter int unsigned CW          = 20
) (
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Control
  input  wire logic       start,
  input  wire logic [2:0] units,
  // State
  output logic            busy,
  output logic            done
);

  localparam logic [CW-1:0] UNIT_LAST = CW'(UNIT_CYCLES - 1);

  logic [CW-1:0] cyc;
  logic [2:0]    left;

  wire unit_end = busy && (cyc == UNIT_LAST);
  wire last     = unit_end && (left == 3'h1);

  // Done marks the final busy cycle so the stall drops exactly on time
  assign done = last;

  // Cycle and unit counters; restart ignored while busy
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy <= 1'b0;
      cyc  <= '0;
      left <= 3'h0;
    end else begin
      if (start && !busy) begin
        busy <= 1'b1;
        cyc  <= '0;
        left <= units;
      end else if (last) begin
        busy <= 1'b0;
      end else if (unit_end) begin
        cyc  <= '0;
        left <= left - 3'h1;
      end else if (busy) begin
        cyc  <= cyc + 1'b1;
      end
    end
  end

endmodule

// *** logic/nvsp_ctrl.sv ***
// Nonvolatile self-program controller with AHB-Lite register slave
//
// Functional notes
// - Nonzero unlock write opens the write function and loads a countdown.
// - Countdown expiry without a command closes writing; later commands fail.
// - Low eight target-address bits held in a read/write byte register.
// - Upper five address bits in second register; its top three reserved.
// - Space 0x00 directs reads and writes to code flash.
// - Space 0x01 reads user-ID region; writes there never performed.
// - Space 0x02 targets EEPROM; other space codes are reserved.
// - Eight-bit data register holds the byte that gets programmed.
// - Stall field 00/01/10 gives 4/2/1 ms hold; 11 reserved.
// - Hold freezes only program counter; other modules keep running.
// - Interrupt flags raised during hold are kept, taken after hold.
// - Repeated interrupts of one source during hold delivered once.
// - Command 10 starts a write when window open; others start nothing.
// - Range option limits code writes: none, 1E00H+, 1C00H+, all.
`timescale 1ns/1ps
module nvsp_ctrl #(
  parameter int unsigned HOLD_UNIT_CYCLES = nvsp_pkg::HOLD_UNIT_CYCLES,
  parameter int unsigned N_IRQ            = 10
) (
  // Clock and reset
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  // AHB-Lite slave
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic [31:0]                 hrdata,
  output logic                        hreadyout,
  output logic                        hresp,
  // Code option
  input  wire logic [1:0]             code_write_range_option,
  // Core side
  output logic                        cpu_stall,
  input  wire logic [N_IRQ-1:0]       irq_flag_in,
  output logic [N_IRQ-1:0]            irq_flag_out,
  // Array side
  output logic [7:0]                  nv_space_code,
  output logic                        nv_write_strobe,
  output nvsp_pkg::nvsp_wr_req_t      nv_write_req
);

  // Register state
  logic [7:0]          unlock_window_count;
  logic [7:0]          address_low_reg;
  logic [4:0]          address_high_reg;
  logic [7:0]          space_select_reg;
  logic [7:0]          program_byte;
  nvsp_pkg::nvsp_ctl_t write_control_reg;
  logic                refused;

  // Bus data-phase state
  logic                dp_write;
  logic [7:0]          dp_idx;

  // Hold timer
  logic                hold_busy;
  logic                hold_done;
  logic [2:0]          hold_units;

  // Address-phase decode
  wire        ap_valid  = hsel && hready && (htrans == nvsp_pkg::HTRANS_NONSEQ);
  wire        ap_mapped = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);
  wire [7:0]  ap_idx    = haddr[9:2];

  // Data-phase write strobes
  wire        wr_key    = dp_write && (dp_idx == nvsp_pkg::IDX_UNLOCK);
  wire        wr_adl    = dp_write && (dp_idx == nvsp_pkg::IDX_ADDR_LOW);
  wire        wr_adh    = dp_write && (dp_idx == nvsp_pkg::IDX_ADDR_HIGH);
  wire        wr_space  = dp_write && (dp_idx == nvsp_pkg::IDX_SPACE);
  wire        wr_data   = dp_write && (dp_idx == nvsp_pkg::IDX_WRITE_BYTE);
  wire        wr_ctl    = dp_write && (dp_idx == nvsp_pkg::IDX_CONTROL);
  wire nvsp_pkg::nvsp_ctl_t ctl_in = nvsp_pkg::nvsp_ctl_t'(hwdata[7:0]);

  // Target address and protection checks
  wire [12:0] nv_target_address = {address_high_reg, address_low_reg};
  wire        window_open = (unlock_window_count != nvsp_pkg::RST_BYTE);
  wire        code_ok =
    (code_write_range_option == nvsp_pkg::RANGE_ALL) ||
    ((code_write_range_option == nvsp_pkg::RANGE_ONE_K) &&
     (nv_target_address >= nvsp_pkg::ONE_K_BASE)) ||
    ((code_write_range_option == nvsp_pkg::RANGE_HALF_K) &&
     (nv_target_address >= nvsp_pkg::HALF_K_BASE));
  wire        space_ok =
    ((space_select_reg == nvsp_pkg::SPACE_CODE) && code_ok) ||
    (space_select_reg == nvsp_pkg::SPACE_EEPROM);
  wire        stall_ok = (ctl_in.stall != nvsp_pkg::STALL_RESERVED);
  wire        cmd_write = wr_ctl && (ctl_in.cmd == nvsp_pkg::CMD_WRITE);
  // Busy hold refuses new commands; the core is frozen anyway
  wire        cmd_accept = cmd_write && window_open && space_ok &&
                           stall_ok && !hold_busy;

  // Hold length from the stall field
  wire [2:0]  next_units =
    (ctl_in.stall == nvsp_pkg::STALL_4MS) ? nvsp_pkg::HOLD_UNITS_4MS :
    (ctl_in.stall == nvsp_pkg::STALL_2MS) ? nvsp_pkg::HOLD_UNITS_2MS :
                                            nvsp_pkg::HOLD_UNITS_1MS;

  // Read mux, sampled in the address phase
  nvsp_pkg::nvsp_status_t status;
  assign status.rsvd    = 5'h00;
  assign status.refused = refused;
  assign status.hold    = hold_busy;
  assign status.open    = window_open;
  wire [7:0] rd_byte =
    (ap_idx == nvsp_pkg::IDX_UNLOCK)     ? unlock_window_count :
    (ap_idx == nvsp_pkg::IDX_ADDR_LOW)   ? address_low_reg :
    (ap_idx == nvsp_pkg::IDX_ADDR_HIGH)  ? {3'h0, address_high_reg} :
    (ap_idx == nvsp_pkg::IDX_SPACE)      ? space_select_reg :
    (ap_idx == nvsp_pkg::IDX_WRITE_BYTE) ? program_byte :
    (ap_idx == nvsp_pkg::IDX_CONTROL)    ? write_control_reg :
    (ap_idx == nvsp_pkg::IDX_STATUS)     ? status : nvsp_pkg::RST_BYTE;

  // Bus slave: zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write  <= 1'b0;
      dp_idx    <= nvsp_pkg::RST_BYTE;
      hrdata    <= nvsp_pkg::RDATA_ZERO;
      hreadyout <= 1'b1;
      hresp     <= nvsp_pkg::HRESP_OKAY;
    end else begin
      dp_write  <= ap_valid && ap_mapped && hwrite;
      dp_idx    <= ap_idx;
      hrdata    <= (ap_valid && ap_mapped && !hwrite) ?
                   {24'h000000, rd_byte} : nvsp_pkg::RDATA_ZERO;
      hreadyout <= 1'b1;
      hresp     <= nvsp_pkg::HRESP_OKAY;
    end
  end

  // Unlock window countdown
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      unlock_window_count <= nvsp_pkg::RST_BYTE;
    end else if (cmd_accept) begin
      unlock_window_count <= nvsp_pkg::RST_BYTE;
    end else if (wr_key) begin
      unlock_window_count <= hwdata[7:0];
    end else if (window_open) begin
      unlock_window_count <= unlock_window_count - 8'h01;
    end
  end

  // Address, space and data registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      address_low_reg  <= nvsp_pkg::RST_BYTE;
      address_high_reg <= nvsp_pkg::RST_ADDR_HIGH;
      space_select_reg <= nvsp_pkg::RST_BYTE;
      program_byte     <= nvsp_pkg::RST_BYTE;
    end else begin
      if (wr_adl)
        address_low_reg  <= hwdata[7:0];
      if (wr_adh)
        address_high_reg <= hwdata[4:0];
      if (wr_space)
        space_select_reg <= hwdata[7:0];
      if (wr_data)
        program_byte     <= hwdata[7:0];
    end
  end

  // Control register, refusal flag and array write strobe
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      write_control_reg <= '0;
      refused           <= 1'b0;
      hold_units        <= 3'h0;
      nv_write_strobe   <= 1'b0;
      nv_write_req      <= '0;
    end else begin
      nv_write_strobe <= cmd_accept;
      if (wr_ctl) begin
        write_control_reg <= {4'h0, ctl_in.stall, ctl_in.cmd};
        refused           <= cmd_write && !cmd_accept;
      end
      if (cmd_accept) begin
        hold_units   <= next_units;
        nv_write_req <= {space_select_reg, nv_target_address,
                         program_byte};
      end
    end
  end

  // Space code to the read path follows the select register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      nv_space_code <= nvsp_pkg::SPACE_CODE;
    else
      nv_space_code <= wr_space ? hwdata[7:0] : space_select_reg;
  end

  nvsp_hold_timer #(
    .UNIT_CYCLES (HOLD_UNIT_CYCLES),
    .CW          (20)
  ) u_hold (
    .hclk    (hclk),
    .hresetn (hresetn),
    .start   (cmd_accept),
    .units   (next_units),
    .busy    (hold_busy),
    .done    (hold_done)
  );

  // Stall mirrors the timer; only the PC sees it, peripherals run on
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      cpu_stall <= 1'b0;
    else
      cpu_stall <= cmd_accept || (hold_busy && !hold_done);
  end

  // Per-source interrupt deferral during the hold
  logic [N_IRQ-1:0] irq_pending;
  genvar gi;
  generate
    for (gi = 0; gi < N_IRQ; gi = gi + 1) begin : g_irq
      // New flags during hold merge into one pending bit
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          irq_pending[gi]  <= 1'b0;
          irq_flag_out[gi] <= 1'b0;
        end else if (cpu_stall) begin
          irq_pending[gi]  <= irq_pending[gi] | irq_flag_in[gi];
          irq_flag_out[gi] <= 1'b0;
        end else begin
          irq_pending[gi]  <= 1'b0;
          irq_flag_out[gi] <= irq_flag_in[gi] | irq_pending[gi];
        end
      end
    end
  endgenerate

  // Helper: cycles spent in the current hold
  logic [22:0] hold_len;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      hold_len <= 23'h000000;
    else if (!cpu_stall)
      hold_len <= 23'h000000;
    else
      hold_len <= hold_len + 23'h000001;
  end

  property p_unlock_opens;
    @(posedge hclk) disable iff (!hresetn)
    (wr_key && (hwdata[7:0] != 8'h00) && !cmd_accept) |=> window_open;
  endproperty
  a_unlock_opens: assert property (p_unlock_opens)
    else $error("nonzero unlock write did not open window");

  property p_window_expires;
    @(posedge hclk) disable iff (!hresetn)
    (unlock_window_count == 8'h01 && !wr_key && !cmd_accept)
      |=> !window_open ##1 (!window_open || $past(wr_key));
  endproperty
  a_window_expires: assert property (p_window_expires)
    else $error("unlock window failed to close on expiry");

  property p_closed_refuses;
    @(posedge hclk) disable iff (!hresetn)
    (cmd_write && !window_open) |=> !nv_write_strobe && refused;
  endproperty
  a_closed_refuses: assert property (p_closed_refuses)
    else $error("command accepted with window closed");

  property p_addr_high_width;
    @(posedge hclk) disable iff (!hresetn)
    wr_adh |=> (address_high_reg == $past(hwdata[4:0]));
  endproperty
  a_addr_high_width: assert property (p_addr_high_width)
    else $error("address high register not loaded from low five bits");

  property p_code_range;
    @(posedge hclk) disable iff (!hresetn)
    (nv_write_strobe && nv_write_req.space == 8'h00) |->
      ($past(code_write_range_option) == 2'h3) ||
      ($past(code_write_range_option) == 2'h2 &&
       nv_write_req.addr >= 13'h1C00) ||
      ($past(code_write_range_option) == 2'h1 &&
       nv_write_req.addr >= 13'h1E00);
  endproperty
  a_code_range: assert property (p_code_range)
    else $error("code write outside permitted range");

  property p_space_legal;
    @(posedge hclk) disable iff (!hresetn)
    nv_write_strobe |->
      (nv_write_req.space == 8'h00) || (nv_write_req.space == 8'h02);
  endproperty
  a_space_legal: assert property (p_space_legal)
    else $error("write issued to user ID or reserved space");

  property p_byte_programmed;
    @(posedge hclk) disable iff (!hresetn)
    nv_write_strobe |-> (nv_write_req.data == $past(program_byte));
  endproperty
  a_byte_programmed: assert property (p_byte_programmed)
    else $error("programmed byte differs from data register");

  property p_hold_length;
    @(posedge hclk) disable iff (!hresetn)
    $fell(cpu_stall) |->
      (hold_len == 23'(hold_units * HOLD_UNIT_CYCLES));
  endproperty
  a_hold_length: assert property (p_hold_length)
    else $error("hold length does not match stall field");

  property p_irq_deferred;
    @(posedge hclk) disable iff (!hresetn)
    (cpu_stall && (irq_flag_in != '0)) |=>
      (irq_flag_out == '0) || !$past(cpu_stall, 2);
  endproperty
  a_irq_deferred: assert property (p_irq_deferred)
    else $error("interrupt passed during hold");

  property p_start_needs_cmd;
    @(posedge hclk) disable iff (!hresetn)
    $rose(cpu_stall) |-> nv_write_strobe && !window_open;
  endproperty
  a_start_needs_cmd: assert property (p_start_needs_cmd)
    else $error("hold started without accepted write command");

  property p_release_closed;
    @(posedge hclk) disable iff (!hresetn)
    $fell(cpu_stall) |-> !hold_busy ##1 !cpu_stall;
  endproperty
  a_release_closed: assert property (p_release_closed)
    else $error("program counter not released at hold end");

  // A second command while the array is busy must start nothing
  property p_busy_refuses;
    @(posedge hclk) disable iff (!hresetn)
    (cmd_write && hold_busy) |=> !nv_write_strobe && refused;
  endproperty
  a_busy_refuses: assert property (p_busy_refuses)
    else $error("command accepted during an active hold");

endmodule

// *** tb/nvsp_far_model.sv ***
// Far-side model: CPU core, peripherals and the nonvolatile arrays
`timescale 1ns/1ps
module nvsp_far_model #(
  parameter int N_IRQ = 10
) (
  // Clock and reset
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  // From the controller
  input  wire logic                   cpu_stall,
  input  wire logic [N_IRQ-1:0]       irq_flag_out,
  input  wire logic                   nv_write_strobe,
  input  wire nvsp_pkg::nvsp_wr_req_t nv_write_req,
  // Peripheral flags
  output logic [N_IRQ-1:0]            irq_flag_in,
  // Observations for the bench
  output int                          n_wr,
  output int                          n_irq,
  output int                          n_irq_hold,
  output int                          last_len,
  output nvsp_pkg::nvsp_wr_req_t      last_req
);
  int run;

  // Arrays take the byte on the strobe; hold length is measured here
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      n_wr        <= 0;
      n_irq       <= 0;
      n_irq_hold  <= 0;
      last_len    <= 0;
      run         <= 0;
      last_req    <= '0;
      irq_flag_in <= '0;
    end else begin
      if (nv_write_strobe) begin
        n_wr     <= n_wr + 1;
        last_req <= nv_write_req;
      end
      run <= cpu_stall ? run + 1 : 0;
      if (!cpu_stall && run != 0) last_len <= run;
      // Peripherals keep running: one source fires twice per hold
      irq_flag_in <= (cpu_stall && (run == 2 || run == 5)) ? N_IRQ'(8) : '0;
      if (irq_flag_out[3] && cpu_stall) n_irq_hold <= n_irq_hold + 1;
      if (irq_flag_out[3] && !cpu_stall) n_irq <= n_irq + 1;
    end
  end
endmodule

// *** tb/nvsp_ctrl_tb.sv ***
// Self-checking bench of the nonvolatile self-program controller
`timescale 1ns/1ps
module nvsp_ctrl_tb;
  localparam int HU    = 20;
  localparam int LIMIT = 20000;

  logic                   hclk;
  logic                   hresetn;
  logic                   hsel;
  logic [31:0]            haddr;
  logic [1:0]             htrans;
  logic                   hwrite;
  logic [2:0]             hsize;
  logic [31:0]            hwdata;
  logic [31:0]            hrdata;
  logic                   hreadyout;
  logic                   hresp;
  logic [1:0]             rng;
  logic                   cpu_stall;
  logic [9:0]             irq_in;
  logic [9:0]             irq_out;
  logic [7:0]             nv_space_code;
  logic                   strobe;
  nvsp_pkg::nvsp_wr_req_t req;
  nvsp_pkg::nvsp_wr_req_t last_req;
  int                     n_wr;
  int                     n_irq;
  int                     n_irq_hold;
  int                     last_len;
  int                     n_mismatch;
  int                     checked;
  int                     cyc;
  logic [31:0]            d;

  nvsp_ctrl #(.HOLD_UNIT_CYCLES(HU), .N_IRQ(10)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .code_write_range_option(rng), .cpu_stall(cpu_stall),
    .irq_flag_in(irq_in), .irq_flag_out(irq_out),
    .nv_space_code(nv_space_code), .nv_write_strobe(strobe),
    .nv_write_req(req));

  nvsp_far_model #(.N_IRQ(10)) far_u (
    .hclk(hclk), .hresetn(hresetn), .cpu_stall(cpu_stall),
    .irq_flag_out(irq_out), .nv_write_strobe(strobe), .nv_write_req(req),
    .irq_flag_in(irq_in), .n_wr(n_wr), .n_irq(n_irq),
    .n_irq_hold(n_irq_hold), .last_len(last_len), .last_req(last_req));

  // Clock and hang guard
  always #25 hclk = ~hclk;
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_mismatch = n_mismatch + 1;
      results();
    end
  end

  task automatic results();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One AHB-Lite single transfer; read data taken at the data-phase edge
  task automatic xfer(input logic w, input logic [7:0] idx,
                      input logic [7:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    htrans <= nvsp_pkg::HTRANS_NONSEQ;
    haddr  <= {22'h000000, idx, 2'h0};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h000000, wd};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk({31'h0, hresp}, {31'h0, nvsp_pkg::HRESP_OKAY});
  endtask

  task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] r;
    xfer(1'b0, idx, 8'h00, r);
    chk(r, {24'h000000, exp});
  endtask

  // Load target, unlock, command, then follow the hold to its end
  task automatic attempt(input logic [7:0] sp, input logic [12:0] a,
                         input logic [7:0] ctl, input logic [7:0] key,
                         input int gap, input logic [7:0] st);
    int w0;
    int i0;
    int units;
    logic [31:0] r;
    w0 = n_wr;
    i0 = n_irq;
    units = (ctl[3:2] == 2'h0) ? 4 : (ctl[3:2] == 2'h1) ? 2 : 1;
    xfer(1'b1, nvsp_pkg::IDX_SPACE, sp, r);
    xfer(1'b1, nvsp_pkg::IDX_WRITE_BYTE, a[7:0] ^ 8'h5A, r);
    xfer(1'b1, nvsp_pkg::IDX_ADDR_HIGH, {3'h0, a[12:8]}, r);
    xfer(1'b1, nvsp_pkg::IDX_ADDR_LOW, a[7:0], r);
    xfer(1'b1, nvsp_pkg::IDX_UNLOCK, key, r);
    repeat (gap) @(posedge hclk);
    xfer(1'b1, nvsp_pkg::IDX_CONTROL, ctl, r);
    repeat (4) @(posedge hclk);
    rchk(nvsp_pkg::IDX_STATUS, st);
    while (cpu_stall !== 1'b0) @(posedge hclk);
    repeat (3) @(posedge hclk);
    rchk(nvsp_pkg::IDX_STATUS, st[1] ? 8'h00 : st);
    chk(32'(n_wr - w0), {31'h0, st[1]});
    chk({24'h0, nv_space_code}, {24'h0, sp});
    if (st[1]) begin
      chk({3'h0, last_req}, {3'h0, sp, a, a[7:0] ^ 8'h5A});
      chk(32'(last_len), 32'(units * HU));
      chk(32'(n_irq - i0), 32'h1);
      chk(32'(n_irq_hold), 32'h0);
    end
  endtask

  logic [7:0]  r_idx [6] = '{8'hF2, 8'hF3, 8'hF4, 8'hF5, 8'hF6, 8'hF0};
  logic [7:0]  r_wd  [6] = '{8'hA5, 8'hFF, 8'h02, 8'hC3, 8'hFF, 8'h77};
  logic [7:0]  r_ex  [6] = '{8'hA5, 8'h1F, 8'h02, 8'hC3, 8'h0F, 8'h00};
  logic [1:0]  g_opt [7] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3};
  logic [12:0] g_adr [7] = '{13'h1FFF, 13'h1E00, 13'h1DFF, 13'h1C00,
                             13'h1BFF, 13'h0000, 13'h1FFF};
  logic        g_ok  [7] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};

  // Main sequence
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    rng = nvsp_pkg::RANGE_ALL;
    n_mismatch = 0;
    checked = 0;
    cyc = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Reset values, then read/write and reserved bits
    for (int i = 0; i < 7; i++) rchk(8'hF1 + 8'(i), 8'h00);
    for (int i = 0; i < 6; i++) begin
      xfer(1'b1, r_idx[i], r_wd[i], d);
      rchk(r_idx[i], r_ex[i]);
    end
    $display("test registers done");
    // Every stall code, reserved one refused
    for (int s = 0; s < 3; s++)
      attempt(nvsp_pkg::SPACE_EEPROM, 13'h007F, {4'h0, 2'(s), 2'h2},
              8'hF0, 0, 8'h02);
    attempt(nvsp_pkg::SPACE_EEPROM, 13'h0011, 8'h0E, 8'hF0, 0, 8'h05);
    xfer(1'b1, nvsp_pkg::IDX_CONTROL, 8'h0A, d);
    rchk(nvsp_pkg::IDX_STATUS, 8'h02);
    xfer(1'b1, nvsp_pkg::IDX_UNLOCK, 8'h08, d);
    xfer(1'b1, nvsp_pkg::IDX_CONTROL, 8'h0A, d);
    rchk(nvsp_pkg::IDX_STATUS, 8'h07);
    while (cpu_stall !== 1'b0) @(posedge hclk);
    xfer(1'b1, nvsp_pkg::IDX_CONTROL, 8'h0A, d);
    rchk(nvsp_pkg::IDX_STATUS, 8'h04);
    $display("test stall done");
    // Non-write commands start nothing
    for (int c = 0; c < 4; c++)
      if (c != 2)
        attempt(nvsp_pkg::SPACE_EEPROM, 13'h0022, {6'h02, 2'(c)},
                8'hF0, 0, 8'h01);
    // Window lapses, zero unlock
    attempt(nvsp_pkg::SPACE_EEPROM, 13'h0033, 8'h0A, 8'h02, 6, 8'h04);
    attempt(nvsp_pkg::SPACE_EEPROM, 13'h0033, 8'h0A, 8'h00, 0, 8'h04);
    $display("test window done");
    // Spaces and code-write ranges
    attempt(nvsp_pkg::SPACE_USER_ID, 13'h0044, 8'h0A, 8'hF0, 0, 8'h05);
    attempt(8'h03, 13'h0044, 8'h0A, 8'hF0, 0, 8'h05);
    for (int g = 0; g < 7; g++) begin
      rng <= g_opt[g];
      attempt(nvsp_pkg::SPACE_CODE, g_adr[g], 8'h0A, 8'hF0, 0,
              g_ok[g] ? 8'h02 : 8'h05);
    end
    $display("test spaces done");
    results();
  end
endmodule
